// ===== common/adccu_pkg.sv
/*
 * Constants, register map and state types of the SAR converter control unit.
 * Assumes a 32-bit APB slave port with one aligned word per register.
 */
package adccu_pkg;
    // ------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PAIR = 8'hba;
    localparam logic [7:0] IDX_CHAN = 8'hbb;
    localparam logic [7:0] IDX_CFG = 8'hbc;
    localparam logic [7:0] IDX_RES_LO = 8'hbe;
    localparam logic [7:0] IDX_RES_HI = 8'hbf;
    localparam logic [7:0] IDX_CTRL = 8'he8;
    localparam int ADDR_LSB = 2;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CFG = 8'hf8;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // ------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------
    localparam int B_EN = 7;
    localparam int B_TM = 6;
    localparam int B_DONE = 5;
    localparam int B_BUSY = 4;
    localparam int B_MODE_HI = 3;
    localparam int B_MODE_LO = 2;
    localparam int B_WIN = 1;
    localparam int B_LJST = 0;
    // Configuration register fields
    localparam int B_DIV_HI = 7;
    localparam int B_DIV_LO = 3;
    localparam int B_GAIN_HI = 2;
    localparam int B_GAIN_LO = 0;
    // ------------------------------------------------------------
    // Start modes, gain codes and timing
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_SW = 2'h0;
    localparam logic [1:0] MODE_T3 = 2'h1;
    localparam logic [1:0] MODE_EXT = 2'h2;
    localparam logic [1:0] MODE_T2 = 2'h3;
    localparam int TRACK_SAR_CLOCKS = 3;
    localparam int CONV_SAR_CLOCKS = 16;
    localparam int RES_W = 10;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TRACK = 3'b010,
        ST_CONV = 3'b100
    } adccu_state_e_t;
    // One-hot gain select: 1, 2, 4, 8, 16, 0.5
    typedef enum logic [5:0] {
        G_X1 = 6'b000001,
        G_X2 = 6'b000010,
        G_X4 = 6'b000100,
        G_X8 = 6'b001000,
        G_X16 = 6'b010000,
        G_HALF = 6'b100000
    } adccu_gain_t;
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
        logic diff;
        logic temp;
    } adccu_mux_t;
    typedef struct packed {
        logic [3:0] pair;
        logic [3:0] chan;
        logic [7:0] cfg;
        logic [7:0] res_lo;
        logic [7:0] res_hi;
        logic en;
        logic tm;
        logic done;
        logic busy;
        logic [1:0] mode;
        logic win;
        logic ljst;
        adccu_state_e_t st;
        logic [4:0] div_cnt;
        logic sar_clk;
        logic [4:0] cnt;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic tracking;
        adccu_mux_t mux;
        adccu_gain_t gain;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } adccu_regs_t;
endpackage

// ===== logic/adccu_top.sv
/*
 * Control unit of a 10-bit SAR converter: APB registers, mux and gain
 * decode, SAR clock divider, start sources, tracking and result format.
 * Assumes the analog core converts while sar_convert is high and holds its
 * raw code on sar_raw when sar_convert falls; window limits come in as ports.
 */
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
// Functional notes
// - Enable bit powers converter, tracker, amplifier
// - Pair bits make even/odd inputs differential
// - Differential results two's complement, single unsigned
// - Channel code selects input, pair, or sensor
// - Upper nibbles of mux registers read zero
// - SAR clock is system clock over div+1
// - Gain code maps to six gains
// - Start mode picks write, timers, external edge
// - Low-power start tracks three SAR clocks
// - External low-power mode tracks while input low
// - Normal mode tracks except during conversion
// - Busy shows conversion; write one starts mode 00
// - Done flag set on busy fall at conversion end (not when disable drops busy), sticky
// - Window flag sticky until software clears
// - Justify bit selects right or left placement
// - Right justify layout with sign extension
// - Left justify layout, low six bits zero
// - Single-ended right justify upper bits zero
// - Conversion lasts sixteen SAR clocks
// - Window compare in or out of limits
module adccu_top
    import adccu_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int TRACK_CLOCKS = TRACK_SAR_CLOCKS,
    parameter int CONV_CLOCKS = CONV_SAR_CLOCKS
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer3_ovf,
    input wire logic timer2_ovf,
    input wire logic ext_convert_start,
    input wire logic [RES_W-1:0] sar_raw,
    input wire logic [15:0] win_gt_limit,
    input wire logic [15:0] win_lt_limit,
    output logic conv_enable,
    output logic track_hold,
    output logic sar_convert,
    output logic sar_conv_clock,
    output adccu_mux_t mux_sel,
    output adccu_gain_t gain_sel
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 10 || TRACK_CLOCKS < 1 || TRACK_CLOCKS > 32 ||
        CONV_CLOCKS < 1 || CONV_CLOCKS > 32)
    begin : g_bad_param
        $error("adccu_top: unsupported parameter value");
    end
    localparam logic [4:0] TRACK_LAST = 5'(TRACK_CLOCKS - 1);
    localparam logic [4:0] CONV_LAST = 5'(CONV_CLOCKS - 1);

    adccu_regs_t r;
    adccu_regs_t next_r;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic wr;
    logic [4:0] div;
    logic tick;
    logic ext_rise;
    logic sw_start;
    logic start_ev;
    logic conv_end;
    logic [RES_W-1:0] res;
    logic [7:0] new_hi;
    logic [7:0] new_lo;
    logic [15:0] word;
    logic gt_hit;
    logic lt_hit;
    logic win_hit;
    logic [2:0] n;

    assign idx = paddr[ADDR_LSB +: 8];
    assign wbyte = pwdata[7:0];
    assign wr = psel && penable && r.pready && pwrite;
    assign div = r.cfg[B_DIV_HI:B_DIV_LO];
    assign tick = (r.div_cnt == div);
    assign ext_rise = r.ext_s2 && !r.ext_s3;
    assign sw_start = wr && idx == IDX_CTRL && wbyte[B_BUSY] && r.mode == MODE_SW;
    assign conv_end = r.st == ST_CONV && tick && r.cnt == CONV_LAST;
    // Differential raw codes are offset binary; flip the MSB for two's complement
    assign res = r.mux.diff ? {~sar_raw[RES_W-1], sar_raw[RES_W-2:0]} : sar_raw;
    assign word = {new_hi, new_lo};
    assign n = r.chan[2:0];

    always_comb
    begin
        case (r.mode)
            MODE_SW: start_ev = sw_start;
            MODE_T3: start_ev = timer3_ovf;
            MODE_EXT: start_ev = ext_rise;
            default: start_ev = timer2_ovf;
        endcase
        start_ev = start_ev && r.en && r.st == ST_IDLE;
        if (r.ljst)
        begin
            new_hi = res[RES_W-1:2];
            new_lo = {res[1:0], 6'h00};
        end
        else
        begin
            new_lo = res[7:0];
            new_hi = {{6{r.mux.diff & res[RES_W-1]}}, res[RES_W-1:8]};
        end
        if (r.mux.diff)
        begin
            gt_hit = $signed(word) > $signed(win_gt_limit);
            lt_hit = $signed(word) < $signed(win_lt_limit);
            win_hit = ($signed(win_lt_limit) > $signed(win_gt_limit)) ?
                      (gt_hit && lt_hit) : (gt_hit || lt_hit);
        end
        else
        begin
            gt_hit = word > win_gt_limit;
            lt_hit = word < win_lt_limit;
            win_hit = (win_lt_limit > win_gt_limit) ? (gt_hit && lt_hit) : (gt_hit || lt_hit);
        end
    end

    always_comb
    begin
        next_r = r;
        // --------------------------------------------------------
        // Synchroniser and SAR clock divider
        // --------------------------------------------------------
        next_r.ext_s1 = ext_convert_start;
        next_r.ext_s2 = r.ext_s1;
        next_r.ext_s3 = r.ext_s2;
        next_r.div_cnt = tick ? 5'h00 : r.div_cnt + 5'h01;
        next_r.sar_clk = next_r.div_cnt <= (div >> 1);
        // --------------------------------------------------------
        // APB slave
        // --------------------------------------------------------
        next_r.pready = 1'b0;
        if (psel && penable && !r.pready)
        begin
            next_r.pready = 1'b1;
            next_r.pslverr = 1'b0;
            next_r.prdata = 32'h0000_0000;
            if (idx == IDX_PAIR)
                next_r.prdata[7:0] = {4'h0, r.pair};
            else if (idx == IDX_CHAN)
                next_r.prdata[7:0] = {4'h0, r.chan};
            else if (idx == IDX_CFG)
                next_r.prdata[7:0] = r.cfg;
            else if (idx == IDX_RES_LO)
                next_r.prdata[7:0] = r.res_lo;
            else if (idx == IDX_RES_HI)
                next_r.prdata[7:0] = r.res_hi;
            else if (idx == IDX_CTRL)
                next_r.prdata[7:0] = {r.en, r.tm, r.done, r.busy, r.mode, r.win, r.ljst};
            else
                next_r.pslverr = 1'b1;
        end
        if (wr)
        begin
            if (idx == IDX_PAIR)
                next_r.pair = wbyte[3:0];
            else if (idx == IDX_CHAN)
                next_r.chan = wbyte[3:0];
            else if (idx == IDX_CFG)
                next_r.cfg = wbyte;
            else if (idx == IDX_RES_LO)
                next_r.res_lo = wbyte;
            else if (idx == IDX_RES_HI)
                next_r.res_hi = wbyte;
            else if (idx == IDX_CTRL)
            begin
                next_r.en = wbyte[B_EN];
                next_r.tm = wbyte[B_TM];
                next_r.done = wbyte[B_DONE];
                next_r.mode = wbyte[B_MODE_HI:B_MODE_LO];
                next_r.win = wbyte[B_WIN];
                next_r.ljst = wbyte[B_LJST];
            end
        end
        // --------------------------------------------------------
        // Conversion sequencer
        // --------------------------------------------------------
        case (r.st)
            ST_IDLE:
            begin
                next_r.cnt = 5'h00;
                if (start_ev)
                begin
                    next_r.busy = 1'b1;
                    next_r.st = (r.tm && r.mode != MODE_EXT) ? ST_TRACK : ST_CONV;
                end
            end
            ST_TRACK:
            begin
                if (tick)
                begin
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == TRACK_LAST)
                    begin
                        next_r.cnt = 5'h00;
                        next_r.st = ST_CONV;
                    end
                end
            end
            ST_CONV:
            begin
                if (tick)
                    next_r.cnt = r.cnt + 5'h01;
                if (conv_end)
                begin
                    next_r.st = ST_IDLE;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.res_hi = new_hi;
                    next_r.res_lo = new_lo;
                    if (win_hit)
                        next_r.win = 1'b1;
                end
            end
            default:
            begin
                next_r.st = ST_IDLE;
            end
        endcase
        if (!r.en)
        begin
            next_r.st = ST_IDLE;
            next_r.busy = 1'b0;
        end
        // --------------------------------------------------------
        // Analog front end controls
        // --------------------------------------------------------
        if (!next_r.en)
            next_r.tracking = 1'b0;
        else if (!next_r.tm)
            next_r.tracking = next_r.st != ST_CONV;
        else
            next_r.tracking = next_r.st == ST_TRACK ||
                (next_r.st == ST_IDLE && next_r.mode == MODE_EXT && !r.ext_s2);
        next_r.mux.temp = r.chan[3];
        next_r.mux.diff = !r.chan[3] && r.pair[n[2:1]];
        next_r.mux.pos = next_r.mux.diff ? {n[2:1], 1'b0} : n;
        next_r.mux.neg = next_r.mux.diff ? {n[2:1], 1'b1} : n;
        case (r.cfg[B_GAIN_HI:B_GAIN_LO])
            3'h0: next_r.gain = G_X1;
            3'h1: next_r.gain = G_X2;
            3'h2: next_r.gain = G_X4;
            3'h3: next_r.gain = G_X8;
            3'h4, 3'h5: next_r.gain = G_X16;
            default: next_r.gain = G_HALF;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
            r.cfg <= RST_CFG;
            r.st <= ST_IDLE;
            r.gain <= G_X1;
            r.sar_clk <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign conv_enable = r.en;
    assign track_hold = r.tracking;
    assign sar_convert = r.st[2];
    assign sar_conv_clock = r.sar_clk;
    assign mux_sel = r.mux;
    assign gain_sel = r.gain;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_done_on_fall;
        @(posedge ref_clk) disable iff (!reset_n) $fell(r.busy) && r.en |-> r.done;
    endproperty
    a_done_on_fall: assert property (p_done_on_fall) else $error("done not set");
    property p_disable_idle;
        @(posedge ref_clk) disable iff (!reset_n)
            !r.en ##1 !r.en |-> r.st == ST_IDLE && !r.busy && !track_hold;
    endproperty
    a_disable_idle: assert property (p_disable_idle) else $error("disabled not idle");
    property p_nibble_zero;
        @(posedge ref_clk) disable iff (!reset_n)
            r.pready && (idx == IDX_PAIR || idx == IDX_CHAN) |-> prdata[7:4] == 4'h0;
    endproperty
    a_nibble_zero: assert property (p_nibble_zero) else $error("upper nibble set");
    property p_sw_start;
        @(posedge ref_clk) disable iff (!reset_n) sw_start && r.en && r.st == ST_IDLE |=> r.busy;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("write did not start");
    property p_conv_len;
        @(posedge ref_clk) disable iff (!reset_n)
            r.st == ST_CONV && $past(r.st) != ST_CONV |-> r.cnt == 5'h00;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion count");
    property p_conv_end;
        @(posedge ref_clk) disable iff (!reset_n)
            $fell(sar_convert) && r.en |-> $past(r.cnt) == CONV_LAST && $past(tick);
    endproperty
    a_conv_end: assert property (p_conv_end) else $error("busy fell in conversion");
    property p_track_len;
        @(posedge ref_clk) disable iff (!reset_n)
            r.st == ST_TRACK && r.en ##1 r.st == ST_CONV |-> $past(r.cnt) == TRACK_LAST;
    endproperty
    a_track_len: assert property (p_track_len) else $error("tracking length");
    property p_right_se;
        @(posedge ref_clk) disable iff (!reset_n)
            conv_end && r.en && !r.ljst && !r.mux.diff |=> r.res_hi[7:2] == 6'h00;
    endproperty
    a_right_se: assert property (p_right_se) else $error("high byte not zero");
    property p_left_low;
        @(posedge ref_clk) disable iff (!reset_n) conv_end && r.en && r.ljst |=> r.res_lo[5:0] == 6'h00;
    endproperty
    a_left_low: assert property (p_left_low) else $error("low bits not zero");
    property p_ext_once;
        @(posedge ref_clk) disable iff (!reset_n)
            ext_rise |-> $past(ext_convert_start, 2) && !$past(ext_convert_start, 3)
            ##1 !ext_rise;
    endproperty
    a_ext_once: assert property (p_ext_once) else $error("double edge");
    property p_normal_track;
        @(posedge ref_clk) disable iff (!reset_n) r.en && !r.tm && r.st == ST_CONV |-> !track_hold;
    endproperty
    a_normal_track: assert property (p_normal_track) else $error("tracked while converting");
    c_sw_conv: cover property (@(posedge ref_clk) disable iff (!reset_n) sw_start ##[1:600] conv_end);
    c_lp_track: cover property (@(posedge ref_clk) disable iff (!reset_n) r.st == ST_TRACK ##1 r.st == ST_CONV);
    c_win_hit: cover property (@(posedge ref_clk) disable iff (!reset_n) conv_end && win_hit);
endmodule

// ===== tb/adccu_core_model.sv
/*
 * Behavioural converter core standing behind the control unit.
 * Assumes the unit raises sar_convert for a conversion and samples
 * sar_raw as it ends; the bench sets the code to return.
 */
`timescale 1ns/1ns
module adccu_core_model
    import adccu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sar_convert,
    input wire logic [RES_W-1:0] code,
    output logic [RES_W-1:0] sar_raw
);
    logic hold;
    logic [RES_W-1:0] junk;
    initial
    begin
        hold = 1'b0;
        junk = 10'h155;
    end
    always @(posedge ref_clk)
    begin
        hold <= sar_convert;
        junk <= ~junk;
    end
    // Code held through the conversion and one cycle after, noise otherwise
    assign sar_raw = (sar_convert || hold) ? code : junk;
endmodule

// ===== tb/tb.sv
/*
 * Self-checking bench of the converter control unit: APB master,
 * start sources and a reference model of result format and flags.
 * Assumes the analog core model answers on sar_raw.
 */
`timescale 1ns/1ns
module tb
    import adccu_pkg::*;
;
    logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata;
    logic timer3_ovf, timer2_ovf, ext_convert_start;
    logic conv_enable, track_hold, sar_convert, sar_conv_clock;
    logic [RES_W-1:0] sar_raw, code;
    logic [15:0] win_gt_limit, win_lt_limit;
    adccu_mux_t mux_sel;
    adccu_gain_t gain_sel;
    int n_fail, checked;

    adccu_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer3_ovf(timer3_ovf), .timer2_ovf(timer2_ovf),
        .ext_convert_start(ext_convert_start), .sar_raw(sar_raw),
        .win_gt_limit(win_gt_limit), .win_lt_limit(win_lt_limit),
        .conv_enable(conv_enable), .track_hold(track_hold), .sar_convert(sar_convert),
        .sar_conv_clock(sar_conv_clock), .mux_sel(mux_sel), .gain_sel(gain_sel));
    adccu_core_model core (.ref_clk(ref_clk), .sar_convert(sar_convert), .code(code),
        .sar_raw(sar_raw));

    always #50 ref_clk = ~ref_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task report_and_stop;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bound(input int n, input int lim);
        if (n >= lim)
        begin
            n_fail++;
            $display("Error t=%0t wait timed out", $time);
            report_and_stop();
        end
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
             output logic [7:0] rd, output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        bound(n, 50);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask
    task rchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        chk(r, exp);
        chk(e, 1'b0);
    endtask
    task pulse(input logic t3);
        @(posedge ref_clk);
        if (t3)
            timer3_ovf <= 1'b1;
        else
            timer2_ovf <= 1'b1;
        @(posedge ref_clk);
        timer3_ovf <= 1'b0;
        timer2_ovf <= 1'b0;
    endtask
    // One conversion from the given start source, checked against the model
    task conv(input logic [1:0] mode, input logic tm, input logic lj, input logic dif);
        logic [9:0] c;
        logic [7:0] hi, lo;
        logic [15:0] w, gt, lt;
        logic wexp;
        int trk, cnv, n;
        c = 10'($urandom);
        gt = dif ? 16'hffff : 16'($urandom);
        lt = dif ? 16'h0000 : 16'($urandom);
        code <= c;
        win_gt_limit <= gt;
        win_lt_limit <= lt;
        wr(IDX_PAIR, {7'h0, dif});
        wr(IDX_CHAN, 8'h00);
        wr(IDX_CTRL, {1'b1, tm, 2'b00, mode, 1'b0, lj});
        repeat (4) @(posedge ref_clk);
        if (!tm || mode == MODE_EXT)
            chk(track_hold, 1'b1);
        if (mode != MODE_SW)
        begin
            wr(IDX_CTRL, {1'b1, tm, 2'b01, mode, 1'b0, lj});
            pulse(mode != MODE_T3);
            repeat (4) @(posedge ref_clk);
            chk(sar_convert, 1'b0);
        end
        case (mode)
            MODE_SW: wr(IDX_CTRL, {1'b1, tm, 2'b01, mode, 1'b0, lj});
            MODE_T3: pulse(1'b1);
            MODE_T2: pulse(1'b0);
            default: @(posedge ref_clk) ext_convert_start <= 1'b1;
        endcase
        trk = 0;
        cnv = 0;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
            if (sar_convert === 1'b1)
                cnv++;
            else if (cnv == 0 && track_hold === 1'b1)
                trk++;
            if (sar_convert === 1'b1)
                chk(track_hold, 1'b0);
        end
        while ((cnv == 0 || sar_convert === 1'b1) && n < 400);
        bound(n, 400);
        chk(cnv >= 16 && cnv <= 17, 1'b1);
        if (tm && mode != MODE_EXT)
            chk(trk >= 3 && trk <= 4, 1'b1);
        c = dif ? c ^ 10'h200 : c;
        hi = lj ? c[9:2] : {{6{dif & c[9]}}, c[9:8]};
        lo = lj ? {c[1:0], 6'h00} : c[7:0];
        w = {hi, lo};
        wexp = dif ? 1'b0 : ((lt > gt) ? (w > gt && w < lt) : (w > gt || w < lt));
        repeat (2) @(posedge ref_clk);
        rchk(IDX_CTRL, {1'b1, tm, 2'b10, mode, wexp, lj});
        rchk(IDX_RES_LO, lo);
        rchk(IDX_RES_HI, hi);
        rchk(IDX_CTRL, {1'b1, tm, 2'b10, mode, wexp, lj});
        @(posedge ref_clk) ext_convert_start <= 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] r, p;
        logic e, d;
        int n, t0;
        ref_clk = 1'b0;
        reset_n = 1'b0;
        {psel, penable, pwrite, timer3_ovf, timer2_ovf, ext_convert_start} = 6'h00;
        paddr = 10'h000;
        pwdata = 32'h0;
        code = 10'h000;
        win_gt_limit = 16'hffff;
        win_lt_limit = 16'h0000;
        n_fail = 0;
        checked = 0;
        void'($urandom(50895));
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        chk(gain_sel, G_X1);
        rchk(IDX_CTRL, RST_ZERO);
        rchk(IDX_CFG, RST_CFG);
        rchk(IDX_PAIR, RST_ZERO);
        rchk(IDX_CHAN, RST_ZERO);
        rchk(IDX_RES_LO, RST_ZERO);
        rchk(IDX_RES_HI, RST_ZERO);
        apb(1'b0, 8'h00, 8'h00, r, e);
        chk({e, r}, 9'h100);
        wr(IDX_RES_LO, 8'h5a);
        rchk(IDX_RES_LO, 8'h5a);
        for (int i = 0; i < 16; i++)
        begin
            p = 8'($urandom) | 8'hf0;
            wr(IDX_PAIR, p);
            wr(IDX_CHAN, 8'hf0 | 8'(i));
            rchk(IDX_PAIR, p & 8'h0f);
            rchk(IDX_CHAN, 8'(i));
            d = !i[3] && p[i[2:1]];
            chk(mux_sel.temp, i[3]);
            chk(mux_sel.diff, d);
            if (!i[3])
                chk(mux_sel.pos, d ? {i[2:1], 1'b0} : i[2:0]);
            if (d)
                chk(mux_sel.neg, {i[2:1], 1'b1});
        end
        for (int g = 0; g < 8; g++)
        begin
            wr(IDX_CFG, 8'(g));
            rchk(IDX_CFG, 8'(g));
            chk(gain_sel, 6'h01 << ((g < 4) ? g : (g < 6) ? 4 : 5));
        end
        wr(IDX_CFG, 8'h18);
        wr(IDX_CTRL, 8'h80);
        @(negedge ref_clk);
        chk(conv_enable, 1'b1);
        n = 0;
        t0 = 0;
        for (int k = 0; k < 2; k++)
        begin
            do
            begin
                @(negedge ref_clk);
                n++;
            end
            while (sar_conv_clock !== 1'b0 && n < 100);
            do
            begin
                @(negedge ref_clk);
                n++;
            end
            while (sar_conv_clock !== 1'b1 && n < 100);
            if (k == 0)
                t0 = n;
        end
        bound(n, 100);
        chk(n - t0, 4);
        wr(IDX_CFG, 8'h00);
        for (int k = 0; k < 16; k++)
            conv(2'(k), k[2], k[3], 1'($urandom));
        wr(IDX_CTRL, 8'h80);
        wr(IDX_CTRL, 8'h90);
        repeat (3) @(posedge ref_clk);
        wr(IDX_CTRL, 8'h00);
        repeat (20) @(posedge ref_clk);
        chk({conv_enable, sar_convert}, 2'b00);
        rchk(IDX_CTRL, 8'h00);
        report_and_stop();
    end
endmodule
